//--- logic/rtcai_top.sv
`timescale 1ns/1ps
`include "rtcai_defines.svh"

module rtcai_top
  import rtcai_pkg::*;
#(
  parameter int RTN_CYCLES = `RTCAI_RTN_CYCLES
)
(
  input  wire logic           sys_clk,
  input  wire logic           rst_b,
  input  wire rtcai_time_t    cur_time,
  input  wire logic           second_tick,
  input  wire logic           minute_tick,
  input  wire rtcai_reg_req_t reg_req,
  output logic [7:0]          reg_rdata,
  output logic                irq_out,
  output logic                irq_oe,
  output logic                alarm_event,
  output logic                update_event
);

  rtcai_state_t st_r;
  rtcai_state_t st_nxt;
  logic         match;
  logic         clock_stop;
  logic         alarm_hit;
  logic         update_hit;
  logic         wr_flags;
  logic         uie_nxt;
  logic         uf_cleared;
  logic         rtn_done;

  // Alarm comparison against the running calendar.
  rtcai_match u_match (
    .alm_min         (st_r.alm_min),
    .alm_hour        (st_r.alm_hour),
    .alm_wd          (st_r.alm_wd),
    .week_day_select (st_r.ext[`RTCAI_BIT_WEEK_DAY_SELECT]),
    .cur_time        (cur_time),
    .match           (match)
  );

  // Event detection: both sources are evaluated on their rollover tick, so the
  // alarm flag appears one clock after the minute tick, far inside its budget.
  always_comb begin
    clock_stop = st_r.ctrl[`RTCAI_BIT_CLOCK_STOP];
    alarm_hit  = minute_tick & ~clock_stop & match;
    update_hit = ~clock_stop & (st_r.ext[`RTCAI_BIT_UPDATE_PERIOD_SELECT] ?
                 minute_tick : second_tick);
  end

  // Next-state logic for registers, flags, release timer and pin drive.
  always_comb begin
    st_nxt              = st_r;
    st_nxt.alarm_event  = alarm_hit;
    st_nxt.update_event = update_hit;
    wr_flags            = reg_req.wr_en & (reg_req.addr == `RTCAI_ADDR_FLAGS);
    uf_cleared          = wr_flags & ~reg_req.wdata[`RTCAI_BIT_UPDATE_FLAG];
    rtn_done            = (st_r.rtn_cnt == 20'h00001);

    // Plain configuration writes.
    if (reg_req.wr_en) begin
      unique case (reg_req.addr)
        `RTCAI_ADDR_ALM_MIN:  st_nxt.alm_min  = reg_req.wdata;
        `RTCAI_ADDR_ALM_HOUR: st_nxt.alm_hour = reg_req.wdata;
        `RTCAI_ADDR_ALM_WD:   st_nxt.alm_wd   = reg_req.wdata;
        `RTCAI_ADDR_EXT:      st_nxt.ext      = reg_req.wdata;
        `RTCAI_ADDR_CTRL:     st_nxt.ctrl     = reg_req.wdata;
        default: ;
      endcase
    end
    uie_nxt = st_nxt.ctrl[`RTCAI_BIT_UPDATE_IRQ_ENABLE];

    // Sticky flags: writing 0 clears, writing 1 is ignored, a new event wins.
    if (wr_flags) begin
      st_nxt.alarm_flag  = st_r.alarm_flag & reg_req.wdata[`RTCAI_BIT_ALARM_FLAG];
      st_nxt.update_flag = st_r.update_flag & reg_req.wdata[`RTCAI_BIT_UPDATE_FLAG];
    end
    if (alarm_hit) begin
      st_nxt.alarm_flag = 1'b1;
    end
    if (update_hit) begin
      st_nxt.update_flag = 1'b1;
    end

    // Update low: a fresh event restarts the window; timeout, flag clear or
    // enable clear ends it early.
    if (update_hit & uie_nxt) begin
      st_nxt.upd_low = 1'b1;
      st_nxt.rtn_cnt = RTN_CYCLES[19:0];
    end else if (st_r.upd_low & (rtn_done | uf_cleared | ~uie_nxt)) begin
      st_nxt.upd_low = 1'b0;
      st_nxt.rtn_cnt = 20'h00000;
    end else if (st_r.upd_low) begin
      st_nxt.rtn_cnt = st_r.rtn_cnt - 20'h00001;
    end

    // Shared open-drain pin: the alarm side holds until flag or enable clears.
    st_nxt.irq_oe = (st_nxt.alarm_flag & st_nxt.ctrl[`RTCAI_BIT_ALARM_IRQ_ENABLE])
                  | st_nxt.upd_low;

    // Registered read data; unmapped offsets and absent bits read zero.
    if (reg_req.rd_en) begin
      unique case (reg_req.addr)
        `RTCAI_ADDR_ALM_MIN:  st_nxt.rdata = st_r.alm_min;
        `RTCAI_ADDR_ALM_HOUR: st_nxt.rdata = st_r.alm_hour;
        `RTCAI_ADDR_ALM_WD:   st_nxt.rdata = st_r.alm_wd;
        `RTCAI_ADDR_EXT:      st_nxt.rdata = st_r.ext;
        `RTCAI_ADDR_CTRL:     st_nxt.rdata = st_r.ctrl;
        `RTCAI_ADDR_FLAGS: begin
          st_nxt.rdata = `RTCAI_RESET_BYTE;
          st_nxt.rdata[`RTCAI_BIT_UPDATE_FLAG] = st_r.update_flag;
          st_nxt.rdata[`RTCAI_BIT_ALARM_FLAG]  = st_r.alarm_flag;
        end
        default: st_nxt.rdata = `RTCAI_RESET_BYTE;
      endcase
    end
  end

  // State register; configuration comes up zero so no interrupt is driven before setup.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from state flops, except irq_out, which is tied to zero; the pin only ever pulls low.
  assign reg_rdata    = st_r.rdata;
  assign irq_out      = 1'b0;
  assign irq_oe       = st_r.irq_oe;
  assign alarm_event  = st_r.alarm_event;
  assign update_event = st_r.update_event;

endmodule

//--- logic/rtcai_defines.svh
`ifndef RTCAI_DEFINES_SVH
`define RTCAI_DEFINES_SVH

// Register offsets on the register port.
`define RTCAI_ADDR_ALM_MIN   8'h17
`define RTCAI_ADDR_ALM_HOUR  8'h18
`define RTCAI_ADDR_ALM_WD    8'h19
`define RTCAI_ADDR_EXT       8'h1c
`define RTCAI_ADDR_FLAGS     8'h1d
`define RTCAI_ADDR_CTRL      8'h1e

// Field positions.
`define RTCAI_BIT_ALARM_COMPARE_DISABLE 7
`define RTCAI_BIT_UPDATE_PERIOD_SELECT  5
`define RTCAI_BIT_WEEK_DAY_SELECT       3
`define RTCAI_BIT_UPDATE_FLAG           5
`define RTCAI_BIT_ALARM_FLAG            3
`define RTCAI_BIT_CLOCK_STOP            6
`define RTCAI_BIT_UPDATE_IRQ_ENABLE     5
`define RTCAI_BIT_ALARM_IRQ_ENABLE      3

// Reset values.
`define RTCAI_RESET_BYTE 8'h00

// Timing: clock rate and the automatic release window in microseconds.
`define RTCAI_CLK_MHZ           20
`define RTCAI_RTN_MIN_US        7570
`define RTCAI_RTN_MAX_US        15630
`define RTCAI_RTN_CYCLES        (`RTCAI_RTN_MIN_US * `RTCAI_CLK_MHZ)
`define RTCAI_RTN_MAX_CYCLES    (`RTCAI_RTN_MAX_US * `RTCAI_CLK_MHZ)
`define RTCAI_RTN_CNT_W         20

`endif

//--- logic/rtcai_pkg.sv
package rtcai_pkg;

  // Running calendar as presented by the timekeeping counters, in BCD except the weekday, which is a bit mask.
  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic [6:0] weekday;
    logic [5:0] date;
  } rtcai_time_t;

  // Register port request from the two-wire front end.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wdata;
  } rtcai_reg_req_t;

  // Whole state of the top module.
  typedef struct packed {
    logic [7:0]  alm_min;
    logic [7:0]  alm_hour;
    logic [7:0]  alm_wd;
    logic [7:0]  ext;
    logic [7:0]  ctrl;
    logic        update_flag;
    logic        alarm_flag;
    logic        upd_low;
    logic [19:0] rtn_cnt;
    logic        irq_oe;
    logic        alarm_event;
    logic        update_event;
    logic [7:0]  rdata;
  } rtcai_state_t;

endpackage

//--- logic/rtcai_match.sv
`timescale 1ns/1ps
`include "rtcai_defines.svh"

// Alarm comparator: decides whether the alarm settings accept the current time.
module rtcai_match
  import rtcai_pkg::*;
(
  input  wire logic [7:0]  alm_min,
  input  wire logic [7:0]  alm_hour,
  input  wire logic [7:0]  alm_wd,
  input  wire logic        week_day_select,
  input  wire rtcai_time_t cur_time,
  output logic             match
);

  // A field passes when its compare is disabled or its value agrees.
  function automatic logic field_ok(input logic disable_bit, input logic equal);
    field_ok = disable_bit | equal;
  endfunction

  logic min_eq;
  logic hour_eq;
  logic wd_eq;

  // Week mode accepts any of several selected weekdays; day mode compares the date.
  always_comb begin
    min_eq  = (alm_min[6:0] == cur_time.minute);
    hour_eq = (alm_hour[5:0] == cur_time.hour);
    if (week_day_select) begin
      wd_eq = (alm_wd[5:0] == cur_time.date);
    end else begin
      wd_eq = |(alm_wd[6:0] & cur_time.weekday);
    end
    // Compare-disable bits are active high: 0 means the field takes part.
    match = field_ok(alm_min[`RTCAI_BIT_ALARM_COMPARE_DISABLE], min_eq)
          & field_ok(alm_hour[`RTCAI_BIT_ALARM_COMPARE_DISABLE], hour_eq)
          & field_ok(alm_wd[`RTCAI_BIT_ALARM_COMPARE_DISABLE], wd_eq);
  end

endmodule

//--- tb/rtcai_host.sv
`timescale 1ns/1ps
// Host behind the two-wire front end: one single-byte access at a time.
module rtcai_host
  import rtcai_pkg::*;
(
  input  wire logic [7:0] reg_rdata,
  input  wire logic       sys_clk,
  output rtcai_reg_req_t  reg_req
);
  initial reg_req = '0;
  // Idle address and data are inverted so that a stale value is never taken as live.
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wr_en: w, rd_en: !w, wdata: d};
    @(posedge sys_clk);
    reg_req <= '{addr: ~a, wr_en: 1'b0, rd_en: 1'b0, wdata: ~d};
    #1 q = reg_rdata;
  endtask
endmodule

//--- tb/rtcai_top_chk.sv
`timescale 1ns/1ps
// Port-level checks of the interrupt block.
module rtcai_top_chk
  import rtcai_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           rst_b,
  input wire logic           second_tick,
  input wire logic           minute_tick,
  input wire rtcai_reg_req_t reg_req,
  input wire logic [7:0]     reg_rdata,
  input wire logic           irq_out,
  input wire logic           irq_oe,
  input wire logic           alarm_event,
  input wire logic           update_event
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_irq_drain: assert property (irq_out == 1'b0)
    else $error("irq data not low");
  a_upd_cause: assert property (update_event |-> $past(second_tick | minute_tick))
    else $error("update without tick");
  a_alm_cause: assert property (alarm_event |-> $past(minute_tick))
    else $error("alarm without minute tick");
  a_alm_pulse: assert property (alarm_event |=> !alarm_event)
    else $error("alarm pulse too long");
  a_upd_pulse: assert property (update_event |=> !update_event)
    else $error("update pulse too long");
  a_irq_rise: assert property ($rose(irq_oe) |-> alarm_event || update_event || $past(reg_req.wr_en))
    else $error("irq without cause");
  a_rdata_hold: assert property (!$past(reg_req.rd_en) |-> $stable(reg_rdata))
    else $error("read data moved");
  a_clr_release: assert property ($past(reg_req.wr_en && reg_req.addr == 8'h1d && reg_req.wdata == 8'h00)
    |-> !irq_oe || alarm_event || update_event)
    else $error("irq held after flag clear");
endmodule

//--- tb/test_rtc_alarm_update_interrupts.sv
`timescale 1ns/1ps
module test_rtc_alarm_update_interrupts;
  import rtcai_pkg::*;
  logic           sys_clk, rst_b, second_tick, minute_tick, irq_out, irq_oe;
  logic           alarm_event, update_event, ae, ue, io;
  logic [7:0]     reg_rdata, q;
  rtcai_time_t    cur_time;
  rtcai_reg_req_t reg_req;
  int             n_fail, checks;
  rtcai_top #(.RTN_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .cur_time(cur_time),
    .second_tick(second_tick), .minute_tick(minute_tick), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .irq_out(irq_out), .irq_oe(irq_oe), .alarm_event(alarm_event), .update_event(update_event));
  rtcai_host host_u (.reg_rdata(reg_rdata), .sys_clk(sys_clk), .reg_req(reg_req));
  // A short release window keeps the run to a few hundred cycles.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.xfer(1'b0, a, 8'h00, q);
  endtask
  // Events are registered, so they are sampled one cycle after the tick.
  task automatic tick(input logic m);
    @(posedge sys_clk);
    minute_tick <= m;
    second_tick <= !m;
    @(posedge sys_clk);
    minute_tick <= 1'b0;
    second_tick <= 1'b0;
    #1 {ae, ue, io} = {alarm_event, update_event, irq_oe};
  endtask
  // One alarm setting tried against the fixed current time.
  task automatic al(input logic [7:0] x, mn, hr, wd, input logic e, ie);
    wr(8'h1d, 8'h00);
    wr(8'h1c, x);
    wr(8'h17, mn);
    wr(8'h18, hr);
    wr(8'h19, wd);
    tick(1'b1);
    chk("alarm_event", ae, e);
    chk("irq_oe", io, e & ie);
    rd(8'h1d);
    chk("flags", q, {4'h0, e, 3'h0});
  endtask
  task automatic t_alm;
    wr(8'h1e, 8'h08);
    al(8'h00, 8'h30, 8'h12, 8'h0a, 1, 1);
    wr(8'h1d, 8'h08);
    rd(8'h1d);
    chk("af_sticky", q, 8'h08);
    al(8'h00, 8'h30, 8'h12, 8'h04, 0, 1);
    al(8'h08, 8'h30, 8'h12, 8'h15, 1, 1);
    al(8'h08, 8'h30, 8'h12, 8'h16, 0, 1);
    al(8'h00, 8'h30, 8'h11, 8'h80, 0, 1);
    al(8'h00, 8'h30, 8'h12, 8'h80, 1, 1);
    al(8'h00, 8'h31, 8'h85, 8'h80, 0, 1);
    al(8'h00, 8'h30, 8'h85, 8'h80, 1, 1);
    wr(8'h1e, 8'h00);
    chk("aie_off", irq_oe, 1'b0);
    al(8'h00, 8'h80, 8'h80, 8'h80, 1, 0);
    $display("alarm test done");
  endtask
  task automatic t_upd;
    wr(8'h1e, 8'h00);
    wr(8'h1c, 8'h00);
    wr(8'h1d, 8'h00);
    wr(8'h1e, 8'h20);
    tick(1'b0);
    chk("update_event", ue, 1'b1);
    chk("irq_oe", io, 1'b1);
    repeat (18) @(posedge sys_clk);
    #1 chk("irq_hold", irq_oe, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq_free", irq_oe, 1'b0);
    wr(8'h1d, 8'h28);
    rd(8'h1d);
    chk("uf_sticky", q, 8'h20);
    wr(8'h1c, 8'h20);
    tick(1'b0);
    chk("sec_tick", ue, 1'b0);
    tick(1'b1);
    chk("min_tick", ue, 1'b1);
    wr(8'h1d, 8'h00);
    chk("uf_clear", irq_oe, 1'b0);
    wr(8'h1e, 8'h40);
    tick(1'b1);
    chk("stopped", {ae, ue}, 8'h00);
    wr(8'h1e, 8'h00);
    tick(1'b1);
    chk("no_enable", {ue, io}, 8'h02);
    $display("update test done");
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {rst_b, second_tick, minute_tick, n_fail, checks} = '0;
    cur_time = {7'h30, 6'h12, 7'h08, 6'h15};
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h1e);
    chk("ctrl_reset", q, 8'h00);
    t_alm;
    t_upd;
    close_out;
  end
  // Hang guard.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    close_out;
  end
endmodule
bind rtcai_top rtcai_top_chk chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .second_tick(second_tick),
  .minute_tick(minute_tick), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_out(irq_out),
  .irq_oe(irq_oe), .alarm_event(alarm_event), .update_event(update_event));
